// >>> core/sadr_decode_remap.sv
// Address decoder with boot remap, peripheral selects and protection.
// Assumes a core that holds a request until ready and a checksum engine.
`timescale 1ns/1ns
module sadr_decode_remap (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Processor request and answer
  input wire sadr_pkg::sadr_req_type req,
  output sadr_pkg::sadr_rsp_type rsp,
  // Selects
  output logic [sadr_pkg::RGN_N-1:0] msel,
  output logic [sadr_pkg::PSLOT_N-1:0] psel,
  output logic [sadr_pkg::WIN_N-1:0] wsel,
  // Checksum engine
  input wire logic chk_done,
  input wire logic chk_pass,
  // Boot and fault status
  output sadr_pkg::sadr_boot_type boot,
  output logic remap,
  output logic fault,
  output logic rst_req
);
  import sadr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_BUSY = 3'b010, ST_DONE = 3'b100
  } sadr_acc_type;
  typedef enum logic [5:0] {
    B_INIT = 6'b000001, B_SHORT = 6'b000010, B_FULL = 6'b000100,
    B_JUMP = 6'b001000, B_HOLD = 6'b010000, B_RUN = 6'b100000
  } sadr_bst_type;

  sadr_acc_type acc_ff, nxt_acc;
  sadr_bst_type bst_ff, nxt_bst;
  logic [3:0] cnt_ff, nxt_cnt;
  sadr_rsp_type rsp_ff, nxt_rsp;
  logic [RGN_N-1:0] msel_ff, nxt_msel;
  logic [PSLOT_N-1:0] psel_ff, nxt_psel;
  logic [WIN_N-1:0] wsel_ff, nxt_wsel;
  sadr_boot_type boot_ff, nxt_boot;
  sadr_rgn_type rgn_ff [RGN_N];
  sadr_rgn_type nxt_rgn [RGN_N];
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [12:0] prot_ff, nxt_prot;
  logic [1:0] fsts_ff, nxt_fsts;
  logic [31:0] pwait_ff, nxt_pwait;
  logic fault_ff, nxt_fault;
  logic rst_req_ff, nxt_rst_req;
  logic [RGN_N-1:0] rgn_hit, rgn_sel;
  logic [PSLOT_N-1:0] slot_hit;
  logic [WIN_N-1:0] win_hit;
  logic is_cfg, take, illegal, denied, cfg_wr;
  logic [7:0] ofs;
  logic [31:0] cfg_rdata;
  logic [4:0] wlog2;

  function automatic logic in_rgn(logic [31:0] a, logic [31:0] b,
                                  logic [4:0] l2);
    logic [31:0] m;
    m = 32'hFFFF_FFFF << l2;
    return ((a ^ b) & m) == 32'h0000_0000;
  endfunction

  assign take = (acc_ff == ST_IDLE) && req.valid;
  assign ofs = req.addr[7:0];
  assign is_cfg = req.addr[31:8] == CFG_PAGE;

  genvar gi;
  generate
    for (gi = 0; gi < RGN_N; gi++) begin : g_rgn
      assign rgn_hit[gi] = ctrl_ff[CTRL_REMAP_BIT] ?
        in_rgn(req.addr, {rgn_ff[gi].base_kb, 10'h000}, rgn_ff[gi].log2) :
        in_rgn(req.addr, RST_BASE[gi], RST_LOG2[gi]);
    end
    for (gi = 0; gi < PSLOT_N; gi++) begin : g_slot
      assign slot_hit[gi] = (req.addr[31:13] == PSLOT_PAGE) &&
                            (req.addr[12:10] == 3'(gi));
    end
    for (gi = 0; gi < WIN_N; gi++) begin : g_win
      assign win_hit[gi] = (req.addr[31:8] == WIN_BASE[gi][31:8]) &&
                           (req.addr[7:0] >= WIN_BASE[gi][7:0]) &&
                           (req.addr[7:0] <= WIN_LAST[gi]);
    end
  endgenerate

  always_comb begin
    rgn_sel = '0;
    if (rgn_hit[RGN_ROM]) begin
      rgn_sel[RGN_ROM] = 1'b1;
    end else if (rgn_hit[RGN_PFLASH]) begin
      rgn_sel[RGN_PFLASH] = 1'b1;
    end else if (rgn_hit[RGN_DFLASH]) begin
      rgn_sel[RGN_DFLASH] = 1'b1;
    end else begin
      rgn_sel[RGN_RAM] = rgn_hit[RGN_RAM];
    end
    illegal = ~(|rgn_hit) & ~(|slot_hit) & ~(|win_hit);
    denied = ~req.priv & (|(rgn_sel & prot_ff[3:0]) |
             |(slot_hit & prot_ff[11:4]) |
             (|win_hit & prot_ff[PROT_WIN_BIT]) |
             (is_cfg & req.write));
    cfg_rdata = 32'h0000_0000;
    unique case (ofs)
      OFS_CTRL: cfg_rdata = {30'h0, ctrl_ff};
      OFS_PROT: cfg_rdata = {19'h0, prot_ff};
      OFS_FAULT: cfg_rdata = {30'h0, fsts_ff};
      OFS_PWAIT: cfg_rdata = pwait_ff;
      default: begin
        if (ofs < OFS_CTRL && ofs[1:0] == 2'h0) begin
          cfg_rdata = {rgn_ff[ofs[3:2]].base_kb, 5'h00,
                       rgn_ff[ofs[3:2]].log2};
        end
      end
    endcase
  end

  // Access sequencing
  always_comb begin
    nxt_acc = acc_ff;
    nxt_cnt = cnt_ff;
    nxt_rsp = rsp_ff;
    nxt_rsp.ready = 1'b0;
    nxt_msel = msel_ff;
    nxt_psel = psel_ff;
    nxt_wsel = wsel_ff;
    nxt_fault = 1'b0;
    nxt_rst_req = 1'b0;
    unique case (acc_ff)
      ST_IDLE: begin
        if (req.valid) begin
          nxt_rsp.rdata = is_cfg ? cfg_rdata : 32'h0000_0000;
          nxt_rsp.error = illegal | denied;
          if (illegal | denied) begin
            // Fault or reset on bad access
            nxt_fault = ~ctrl_ff[CTRL_RSTACT_BIT];
            nxt_rst_req = ctrl_ff[CTRL_RSTACT_BIT];
            nxt_cnt = MEM_WAIT;
          end else begin
            nxt_msel = rgn_sel;
            nxt_psel = slot_hit;
            nxt_wsel = win_hit;
            nxt_cnt = is_cfg ? CFG_WAIT : MEM_WAIT;
            for (int i = 0; i < PSLOT_N; i++) begin
              if (slot_hit[i]) begin
                nxt_cnt = pwait_ff[4*i +: 4];
              end
            end
          end
          nxt_acc = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (cnt_ff == 4'h0) begin
          nxt_acc = ST_DONE;
          nxt_rsp.ready = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      ST_DONE: begin
        nxt_acc = ST_IDLE;
        nxt_msel = '0;
        nxt_psel = '0;
        nxt_wsel = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      rsp_ff <= '0;
      msel_ff <= '0;
      psel_ff <= '0;
      wsel_ff <= '0;
      fault_ff <= 1'b0;
      rst_req_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      cnt_ff <= nxt_cnt;
      rsp_ff <= nxt_rsp;
      msel_ff <= nxt_msel;
      psel_ff <= nxt_psel;
      wsel_ff <= nxt_wsel;
      fault_ff <= nxt_fault;
      rst_req_ff <= nxt_rst_req;
    end
  end

  // Configuration registers and boot sequence
  always_comb begin
    cfg_wr = take & is_cfg & req.write & req.priv;
    nxt_rgn = rgn_ff;
    nxt_ctrl = ctrl_ff;
    nxt_prot = prot_ff;
    nxt_pwait = pwait_ff;
    nxt_fsts = fsts_ff;
    nxt_bst = bst_ff;
    nxt_boot = boot_ff;
    nxt_boot.chk_start = 1'b0;
    nxt_boot.jump = 1'b0;
    wlog2 = req.wdata[4:0];
    if (wlog2 < LOG2_MIN) begin
      wlog2 = LOG2_MIN;
    end else if (wlog2 > LOG2_MAX) begin
      wlog2 = LOG2_MAX;
    end
    if (cfg_wr) begin
      unique case (ofs)
        // Single write swaps the whole map
        OFS_CTRL: nxt_ctrl = req.wdata[1:0];
        OFS_PROT: nxt_prot = req.wdata[12:0];
        OFS_FAULT: nxt_fsts = fsts_ff & ~req.wdata[1:0];
        OFS_PWAIT: nxt_pwait = req.wdata;
        default: begin
          if (ofs < OFS_CTRL && ofs[1:0] == 2'h0) begin
            nxt_rgn[ofs[3:2]] = {req.wdata[31:10], wlog2};
          end
        end
      endcase
    end
    if (take) begin
      nxt_fsts[FAULT_ILL_BIT] = nxt_fsts[FAULT_ILL_BIT] | illegal;
      nxt_fsts[FAULT_PROT_BIT] = nxt_fsts[FAULT_PROT_BIT] |
                                 (denied & ~illegal);
    end
    unique case (bst_ff)
      B_INIT: begin
        nxt_bst = B_SHORT;
        nxt_boot.chk_start = 1'b1;
        nxt_boot.chk_full = 1'b0;
      end
      B_SHORT: begin
        if (chk_done) begin
          nxt_bst = chk_pass ? B_JUMP : B_FULL;
          nxt_boot.chk_start = ~chk_pass;
          nxt_boot.chk_full = ~chk_pass;
        end
      end
      B_FULL: begin
        if (chk_done) begin
          nxt_bst = chk_pass ? B_JUMP : B_HOLD;
          nxt_boot.pmbus_mode = ~chk_pass;
        end
      end
      B_JUMP: begin
        if (acc_ff == ST_IDLE && !req.valid) begin
          nxt_bst = B_RUN;
          nxt_boot.jump = 1'b1;
          nxt_ctrl[CTRL_REMAP_BIT] = 1'b1;
        end
      end
      // Stay in ROM until host remaps
      B_HOLD: begin
        if (nxt_ctrl[CTRL_REMAP_BIT]) begin
          nxt_bst = B_RUN;
          nxt_boot.pmbus_mode = 1'b0;
        end
      end
      B_RUN: nxt_bst = B_RUN;
      default: nxt_bst = B_INIT;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < RGN_N; i++) begin
        rgn_ff[i] <= {NORM_BASE_KB[i], NORM_LOG2[i]};
      end
      ctrl_ff <= CTRL_RST;
      prot_ff <= PROT_RST;
      pwait_ff <= PWAIT_RST;
      fsts_ff <= 2'h0;
      bst_ff <= B_INIT;
      boot_ff <= '0;
    end else begin
      rgn_ff <= nxt_rgn;
      ctrl_ff <= nxt_ctrl;
      prot_ff <= nxt_prot;
      pwait_ff <= nxt_pwait;
      fsts_ff <= nxt_fsts;
      bst_ff <= nxt_bst;
      boot_ff <= nxt_boot;
    end
  end

  assign rsp = rsp_ff;
  assign msel = msel_ff;
  assign psel = psel_ff;
  assign wsel = wsel_ff;
  assign boot = boot_ff;
  assign remap = ctrl_ff[CTRL_REMAP_BIT];
  assign fault = fault_ff;
  assign rst_req = rst_req_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_cfg_done;
    (!rsp_ff.ready) ##2 rsp_ff.ready;
  endsequence
  sequence s_user_take;
    take && !req.priv;
  endsequence

  chk_rom_mirror: assert property (
    take && !remap && req.addr[31:16] == 16'h0000 && !req.priv == 1'b0
    |=> msel_ff[RGN_ROM] && $onehot(msel_ff))
    else $error("ROM not selected in reset map");
  chk_reset_pflash: assert property (
    take && !remap && req.addr[31:15] == 17'h00002 && req.priv
    |=> msel_ff[RGN_PFLASH])
    else $error("Program flash missing in reset map");
  chk_normal_pflash: assert property (
    take && remap && req.addr[31:15] == 17'h0 && req.priv &&
    rgn_ff[RGN_PFLASH] == {NORM_BASE_KB[1], NORM_LOG2[1]}
    |=> msel_ff[RGN_PFLASH])
    else $error("Program flash not at zero after remap");
  chk_cfg_wait: assert property (
    take && is_cfg && !illegal && !denied |=> s_cfg_done)
    else $error("Configuration access wait state wrong");
  chk_user_write: assert property (
    s_user_take ##0 is_cfg && req.write
    |=> ctrl_ff == $past(ctrl_ff) && prot_ff == $past(prot_ff))
    else $error("User write changed configuration");
  chk_psel_onehot: assert property (
    $onehot0(psel_ff) && (!(|psel_ff) || acc_ff != ST_IDLE))
    else $error("Peripheral selects malformed");
  chk_periph_stretch: assert property (
    take && slot_hit[0] && !denied && pwait_ff[3:0] == 4'h3
    |=> !rsp_ff.ready [*4] ##1 rsp_ff.ready)
    else $error("Peripheral stretch count wrong");
  chk_prot_block: assert property (
    s_user_take ##0 |(rgn_sel & prot_ff[3:0])
    |=> msel_ff == '0 ##1 rsp_ff.ready && rsp_ff.error)
    else $error("Protected region reached from user mode");
  chk_fault_raise: assert property (
    take && illegal |=> (fault_ff ^ rst_req_ff) && fsts_ff[FAULT_ILL_BIT])
    else $error("Illegal access not reported");
  chk_boot_short: assert property (
    bst_ff == B_SHORT && chk_done && chk_pass
    |=> bst_ff == B_JUMP ##[1:300] boot_ff.jump && remap)
    else $error("Short checksum pass did not jump");
  chk_boot_hold: assert property (
    bst_ff == B_FULL && chk_done && !chk_pass
    |=> boot_ff.pmbus_mode && !remap)
    else $error("Failed boot did not hold in ROM");
  chk_remap_atomic: assert property (
    $changed(remap) |-> $past(acc_ff) == ST_IDLE && $past(msel_ff) == '0)
    else $error("Map switched during an access");
endmodule

// >>> core/sadr_pkg.sv
// Constants, maps and carrier types of the system address decoder.
// Assumes one processor clock domain and a single requesting core.
package sadr_pkg;
  // Regions: 0 boot ROM, 1 program flash, 2 data flash, 3 data RAM
  localparam int RGN_N = 4;
  localparam int RGN_ROM = 0;
  localparam int RGN_PFLASH = 1;
  localparam int RGN_DFLASH = 2;
  localparam int RGN_RAM = 3;
  // Reset map, ROM window covers 64K and mirrors the 4K array
  localparam logic [31:0] RST_BASE [RGN_N] =
    '{32'h0000_0000, 32'h0001_0000, 32'h0001_8800, 32'h0001_9000};
  localparam logic [4:0] RST_LOG2 [RGN_N] =
    '{5'h10, 5'h0F, 5'h0B, 5'h0C};
  // Normal map, reset values of the region registers
  localparam logic [21:0] NORM_BASE_KB [RGN_N] =
    '{22'h000040, 22'h000000, 22'h000062, 22'h000064};
  localparam logic [4:0] NORM_LOG2 [RGN_N] =
    '{5'h0C, 5'h0F, 5'h0B, 5'h0C};
  localparam logic [4:0] LOG2_MIN = 5'h0A;
  localparam logic [4:0] LOG2_MAX = 5'h18;
  // Decoder configuration window and its register offsets
  localparam logic [23:0] CFG_PAGE = 24'hFFFFFE;
  localparam logic [7:0] OFS_RGN0 = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_PROT = 8'h14;
  localparam logic [7:0] OFS_FAULT = 8'h18;
  localparam logic [7:0] OFS_PWAIT = 8'h1C;
  localparam int CTRL_REMAP_BIT = 0;
  localparam int CTRL_RSTACT_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [12:0] PROT_RST = 13'h0000;
  localparam logic [31:0] PWAIT_RST = 32'h0000_0000;
  localparam int PROT_WIN_BIT = 12;
  localparam int FAULT_ILL_BIT = 0;
  localparam int FAULT_PROT_BIT = 1;
  // Eight 1K peripheral slots
  localparam int PSLOT_N = 8;
  localparam logic [18:0] PSLOT_PAGE = 19'h7FFBF;
  // Wait counts
  localparam logic [3:0] MEM_WAIT = 4'h0;
  localparam logic [3:0] CFG_WAIT = 4'h1;
  // Fixed system and peripheral windows
  localparam int WIN_N = 24;
  localparam logic [31:0] WIN_BASE [WIN_N] = '{
    32'h0002_0000, 32'h0003_0000, 32'h0004_0000, 32'h0005_0000,
    32'h0006_0000, 32'h0007_0000, 32'h0008_0000, 32'h0009_0000,
    32'h000A_0000, 32'h000B_0000, 32'h000C_0000, 32'h000D_0000,
    32'h000E_0000, 32'hFFF7_EC00, 32'hFFF7_ED00, 32'hFFF7_F000,
    32'hFFF7_F600, 32'hFFF7_FA00, 32'hFFF7_FD00, 32'hFFFF_FD00,
    32'hFFFF_FE00, 32'hFFFF_FF20, 32'hFFFF_FF40, 32'hFFFF_FFD0};
  localparam logic [7:0] WIN_LAST [WIN_N] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h37, 8'h50, 8'hEC};

  typedef struct packed {
    logic valid;
    logic write;
    logic priv;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sadr_req_type;

  typedef struct packed {
    logic ready;
    logic error;
    logic [31:0] rdata;
  } sadr_rsp_type;

  typedef struct packed {
    logic [21:0] base_kb;
    logic [4:0] log2;
  } sadr_rgn_type;

  typedef struct packed {
    logic chk_start;
    logic chk_full;
    logic jump;
    logic pmbus_mode;
  } sadr_boot_type;
endpackage

// >>> tb/sadr_core_model.sv
// Behavioural processor core and checksum engine facing the decoder.
// Assumes the bench calls access() just after a falling clock edge.
`timescale 1ns/1ns
module sadr_core_model (
  // Clock and reset
  input logic clk,
  input logic nrst,
  // Processor bus
  output sadr_pkg::sadr_req_type req,
  input sadr_pkg::sadr_rsp_type rsp,
  input logic [3:0] msel,
  input logic [7:0] psel,
  input logic [23:0] wsel,
  input logic fault,
  input logic rst_req,
  // Checksum engine
  input sadr_pkg::sadr_boot_type boot,
  output logic chk_done,
  output logic chk_pass
);
  import sadr_pkg::*;
  logic short_ok = 1'b0;
  logic full_ok = 1'b0;
  logic timed_out = 1'b0;
  logic full_q;
  logic flt_q;
  logic rst_q;
  logic [3:0] ms_q;
  logic [7:0] ps_q;
  logic [23:0] ws_q;
  sadr_rsp_type rsp_q;
  int lat;
  int cnt;

  initial begin
    req = '0;
  end

  // Request held until ready, then released
  task automatic access(input logic wr, pv, input logic [31:0] a, d);
    req.valid = 1'b1;
    req.write = wr;
    req.priv = pv;
    req.addr = a;
    req.wdata = d;
    lat = 0;
    flt_q = 1'b0;
    rst_q = 1'b0;
    do begin
      @(negedge clk);
      lat++;
      if (lat == 1) begin
        ms_q = msel;
        ps_q = psel;
        ws_q = wsel;
      end
      flt_q = flt_q | fault;
      rst_q = rst_q | rst_req;
    end while (rsp.ready !== 1'b1 && lat < 40);
    timed_out = (rsp.ready !== 1'b1);
    rsp_q = rsp;
    req.valid = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
    @(negedge clk);
    flt_q = flt_q | fault;
    rst_q = rst_q | rst_req;
  endtask

  always @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt = 0;
      chk_done <= 1'b0;
      chk_pass <= 1'b0;
    end else begin
      chk_done <= 1'b0;
      chk_pass <= ~chk_pass;
      if (boot.chk_start === 1'b1) begin
        full_q = boot.chk_full;
        cnt = 3;
      end else if (cnt != 0) begin
        cnt = cnt - 1;
        if (cnt == 0) begin
          chk_done <= 1'b1;
          chk_pass <= full_q ? full_ok : short_ok;
        end
      end
    end
  end
endmodule

// >>> tb/tb_system_address_decode_remap.sv
// Self-checking bench for the address decoder with boot remap.
// Assumes the core model drives the bus and the checksum link.
`timescale 1ns/1ns
module tb_system_address_decode_remap;
  import sadr_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  sadr_req_type req;
  sadr_rsp_type rsp;
  logic [RGN_N-1:0] msel;
  logic [PSLOT_N-1:0] psel;
  logic [WIN_N-1:0] wsel;
  logic chk_done;
  logic chk_pass;
  sadr_boot_type boot;
  logic remap;
  logic fault;
  logic rst_req;
  int errors = 0;
  int comparisons = 0;
  logic [31:0] rm_a [5] = '{32'h0000_0000, 32'h0000_F004, 32'h0001_0000,
    32'h0001_8800, 32'h0001_9FFC};
  logic [3:0] rm_m [5] = '{4'h1, 4'h1, 4'h2, 4'h4, 4'h8};
  logic [31:0] nm_a [5] = '{32'h0000_0000, 32'h0000_7FFC, 32'h0001_0000,
    32'h0001_8800, 32'h0001_9000};
  logic [3:0] nm_m [5] = '{4'h2, 4'h2, 4'h1, 4'h4, 4'h8};
  logic [31:0] wn_a [4] = '{32'h0002_0000, 32'hFFF7_ECFC, 32'hFFFF_FF20,
    32'hFFFF_FFEC};
  int wn_i [4] = '{0, 13, 21, 23};

  always #10 clk = ~clk;

  sadr_decode_remap sadr_decode_remap_inst (
    .clk(clk), .nrst(nrst), .req(req), .rsp(rsp), .msel(msel),
    .psel(psel), .wsel(wsel), .chk_done(chk_done), .chk_pass(chk_pass),
    .boot(boot), .remap(remap), .fault(fault), .rst_req(rst_req));

  sadr_core_model sadr_core_model_inst (
    .clk(clk), .nrst(nrst), .req(req), .rsp(rsp), .msel(msel),
    .psel(psel), .wsel(wsel), .fault(fault), .rst_req(rst_req),
    .boot(boot), .chk_done(chk_done), .chk_pass(chk_pass));

  task automatic check(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One access, then latency, error and fault seen
  task automatic acc(input logic wr, pv, input logic [31:0] a, d,
                     input int lat, input logic err, flt);
    sadr_core_model_inst.access(wr, pv, a, d);
    if (sadr_core_model_inst.timed_out) begin
      errors++;
      print_verdict();
    end else begin
      check(sadr_core_model_inst.lat, lat);
      check(sadr_core_model_inst.rsp_q.error, err);
      check(sadr_core_model_inst.flt_q, flt);
    end
  endtask

  task automatic boot_case(input logic s_ok, f_ok);
    int i;
    logic first;
    logic full_seen;
    logic jumped;
    @(negedge clk);
    nrst = 1'b0;
    sadr_core_model_inst.short_ok = s_ok;
    sadr_core_model_inst.full_ok = f_ok;
    repeat (6) @(negedge clk);
    check({remap, boot, msel, fault, rst_req}, 0);
    nrst = 1'b1;
    first = 1'b1;
    full_seen = 1'b0;
    jumped = 1'b0;
    for (i = 0; i < 60; i++) begin
      @(negedge clk);
      if (boot.chk_start === 1'b1 && first) begin
        first = 1'b0;
        check(i, 0);
        check(boot.chk_full, 0);
      end
      if (boot.chk_start === 1'b1 && boot.chk_full === 1'b1)
        full_seen = 1'b1;
      if (boot.jump === 1'b1)
        jumped = 1'b1;
      check(remap, jumped);
    end
    check(full_seen, !s_ok);
    check(jumped, s_ok | f_ok);
    check(boot.pmbus_mode, !(s_ok | f_ok));
  endtask

  task automatic map_case(input logic [31:0] a [5], input logic [3:0] m [5],
                          input logic [31:0] bad);
    int i;
    for (i = 0; i < 5; i++) begin
      acc(1'b0, 1'b1, a[i], 0, 2, 1'b0, 1'b0);
      check(sadr_core_model_inst.ms_q, m[i]);
    end
    acc(1'b0, 1'b1, bad, 0, 2, 1'b1, 1'b1);
    check(sadr_core_model_inst.ms_q, 0);
  endtask

  task automatic window_case();
    int i;
    for (i = 0; i < 4; i++) begin
      acc(1'b0, 1'b1, wn_a[i], 0, 2, 1'b0, 1'b0);
      check(sadr_core_model_inst.ws_q, 24'h000001 << wn_i[i]);
    end
  endtask

  task automatic host_load_case();
    acc(1'b1, 1'b0, 32'hFFFF_FE10, 32'h1, 2, 1'b1, 1'b1);
    check(remap, 0);
    acc(1'b1, 1'b1, 32'hFFFF_FE10, 32'h1, 3, 1'b0, 1'b0);
    check(remap, 1);
    check(boot.pmbus_mode, 0);
  endtask

  task automatic config_case();
    acc(1'b0, 1'b1, 32'hFFFF_FE00, 0, 3, 1'b0, 1'b0);
    check(sadr_core_model_inst.rsp_q.rdata, 32'h0001_000C);
    // Size below 1K clamps to 1K
    acc(1'b1, 1'b1, 32'hFFFF_FE0C, 32'h00F0_0003, 3, 1'b0, 1'b0);
    acc(1'b0, 1'b1, 32'h00F0_03FC, 0, 2, 1'b0, 1'b0);
    check(sadr_core_model_inst.ms_q, 4'h8);
    acc(1'b0, 1'b1, 32'h00F0_0400, 0, 2, 1'b1, 1'b1);
    acc(1'b1, 1'b1, 32'hFFFF_FE1C, 32'h0000_0F03, 3, 1'b0, 1'b0);
    acc(1'b0, 1'b1, 32'hFFF7_E800, 0, 17, 1'b0, 1'b0);
    check(sadr_core_model_inst.ps_q, 8'h04);
    acc(1'b0, 1'b1, 32'hFFF7_E3FC, 0, 5, 1'b0, 1'b0);
    check(sadr_core_model_inst.ps_q, 8'h01);
    acc(1'b1, 1'b1, 32'hFFFF_FE14, 32'h8, 3, 1'b0, 1'b0);
    acc(1'b0, 1'b0, 32'h00F0_0000, 0, 2, 1'b1, 1'b1);
    acc(1'b0, 1'b1, 32'h00F0_0000, 0, 2, 1'b0, 1'b0);
    acc(1'b1, 1'b1, 32'hFFFF_FE10, 32'h3, 3, 1'b0, 1'b0);
    acc(1'b1, 1'b0, 32'hFFFF_FE14, 32'h0, 2, 1'b1, 1'b0);
    check(sadr_core_model_inst.rst_q, 1);
    acc(1'b0, 1'b1, 32'hFFFF_FE14, 0, 3, 1'b0, 1'b0);
    check(sadr_core_model_inst.rsp_q.rdata, 32'h8);
    acc(1'b0, 1'b1, 32'hFFFF_FE18, 0, 3, 1'b0, 1'b0);
    check(sadr_core_model_inst.rsp_q.rdata, 32'h3);
    // Write one clears the illegal flag only
    acc(1'b1, 1'b1, 32'hFFFF_FE18, 32'h1, 3, 1'b0, 1'b0);
    acc(1'b0, 1'b1, 32'hFFFF_FE18, 0, 3, 1'b0, 1'b0);
    check(sadr_core_model_inst.rsp_q.rdata, 32'h2);
  endtask

  initial begin
    boot_case(1'b0, 1'b0);
    map_case(rm_a, rm_m, 32'h0001_8000);
    host_load_case();
    map_case(nm_a, nm_m, 32'h0001_1000);
    window_case();
    config_case();
    boot_case(1'b1, 1'b0);
    boot_case(1'b0, 1'b1);
    print_verdict();
  end
endmodule
